// File: design/mbb_host_port.sv
// muxed address/data host port, device side
`timescale 1ns/1ps
// Operation
// - a high bus_style_select chooses strobe-style timing, low or open chooses write-enable-style timing.
// - the host drives the address first and the device latches it on the falling address_strobe.
// - in strobe style write data is latched on the falling data_strobe.
// - in write-enable style write data is latched on the rising edge of the read/write line.
// - in strobe style read data is driven while data_strobe and read/write are both high.
// - in write-enable style read data is driven while data_strobe is low and read/write high.
// - in strobe style the read ends and the lines float when data_strobe falls.
// - in write-enable style the read ends and the lines float when data_strobe rises.
// - the timebase is a 32.768kHz source, own crystal or external, with osc_output floating for external.
// - chip select must stay low over the strobes, and a cycle without it latches the address only.
// - the latched address is dropped at the next rising address_strobe, and until then it serves every access that follows.
// - below the power-fail threshold chip select is ignored and every access is blocked.
module mbb_host_port (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic bus_style_select,
  input wire mbb_pkg::mbb_ctl_s ctl_pins,
  input wire logic [mbb_pkg::DATA_W-1:0] shared_bus_lines_i,
  output logic [mbb_pkg::DATA_W-1:0] shared_bus_lines_o,
  output logic shared_bus_lines_oe,
  input wire logic power_fail,
  input wire logic ext_osc_sel,
  input wire logic osc_input,
  output logic osc_output,
  output logic osc_output_oe,
  output logic tick_q,
  output mbb_pkg::mbb_req_s req_q,
  output logic req_valid_q,
  output logic rd_strobe_q,
  output logic [mbb_pkg::DATA_W-1:0] rd_addr_q,
  input wire logic [mbb_pkg::DATA_W-1:0] rd_data
);
  logic [7:0] pins_s;
  logic [mbb_pkg::DATA_W-1:0] bus_s;
  mbb_pkg::mbb_ctl_s c, p;
  logic style_s;
  logic pf_s;
  logic osc_s, osc_p;
  logic [mbb_pkg::DATA_W-1:0] addr_q;
  logic addr_ok_q;
  logic sel;

  mbb_sync #(.W(8)) u_sync_ctl (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .async_in({bus_style_select, ctl_pins, power_fail, osc_input, ext_osc_sel}),
    .sync_out(pins_s)
  );
  mbb_sync #(.W(mbb_pkg::DATA_W)) u_sync_bus (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .async_in(shared_bus_lines_i),
    .sync_out(bus_s)
  );

  logic ext_s;
  assign style_s = pins_s[7];
  assign c = pins_s[6:3];
  assign pf_s = pins_s[2];
  assign osc_s = pins_s[1];
  assign ext_s = pins_s[0];
  // chip select masked under power fail
  assign sel = !c.cs_n && !pf_s;

  always_ff @(posedge sys_clk)
  begin
    // same level as the synchroniser reset, so no false strobe edge follows reset
    if (!rstn)
      p <= '0;
    else
      p <= c;
  end

  // address latch
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      addr_q <= 8'h00;
      addr_ok_q <= 1'b0;
    end
    else if (p.addr_strobe && !c.addr_strobe)
    begin
      addr_q <= bus_s;
      addr_ok_q <= 1'b1;
    end
    else if (!p.addr_strobe && c.addr_strobe)
      addr_ok_q <= 1'b0;
  end

  // write capture: strobe style on falling data_strobe, else on rising rw
  logic wr_edge;
  assign wr_edge = style_s ? (p.data_strobe && !c.data_strobe && !c.rw)
                       : (!p.rw && c.rw);
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      req_q <= '0;
      req_valid_q <= 1'b0;
    end
    else
    begin
      req_valid_q <= wr_edge && sel && addr_ok_q;
      if (wr_edge && sel && addr_ok_q)
      begin
        req_q.addr <= addr_q;
        req_q.data <= bus_s;
        req_q.wr <= 1'b1;
      end
    end
  end

  // read window; drive ends with the data_strobe edge that closes it
  logic rd_win;
  assign rd_win = sel && addr_ok_q && c.rw
    && (style_s ? c.data_strobe : !c.data_strobe);
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      shared_bus_lines_oe <= 1'b0;
      shared_bus_lines_o <= 8'h00;
      rd_strobe_q <= 1'b0;
      rd_addr_q <= 8'h00;
    end
    else
    begin
      shared_bus_lines_oe <= rd_win;
      shared_bus_lines_o <= rd_win ? rd_data : 8'h00;
      rd_strobe_q <= rd_win && !shared_bus_lines_oe;
      rd_addr_q <= addr_q;
    end
  end

  // timebase: one tick per 32.768kHz period
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      osc_p <= 1'b0;
      tick_q <= 1'b0;
      osc_output <= 1'b0;
      osc_output_oe <= 1'b0;
    end
    else
    begin
      osc_p <= osc_s;
      tick_q <= osc_s && !osc_p;
      osc_output <= !osc_s;
      osc_output_oe <= !ext_s; // external source leaves the output floating
    end
  end

  property p_rd_drive;
    @(posedge sys_clk) disable iff (!rstn) rd_win |=> shared_bus_lines_oe;
  endproperty
  a_rd_drive: assert property (p_rd_drive)
    else $error("read data not driven");

  property p_rd_release;
    @(posedge sys_clk) disable iff (!rstn) !rd_win |=> !shared_bus_lines_oe;
  endproperty
  a_rd_release: assert property (p_rd_release)
    else $error("bus not released");

  property p_rd_data;
    @(posedge sys_clk) disable iff (!rstn) shared_bus_lines_oe |-> shared_bus_lines_o == $past(rd_data);
  endproperty
  a_rd_data: assert property (p_rd_data)
    else $error("read data wrong");

  property p_rd_end_strobe;
    @(posedge sys_clk) disable iff (!rstn)
      (style_s && p.data_strobe && !c.data_strobe) |=> !shared_bus_lines_oe;
  endproperty
  a_rd_end_strobe: assert property (p_rd_end_strobe)
    else $error("bus held after falling data strobe");

  property p_rd_end_we;
    @(posedge sys_clk) disable iff (!rstn)
      (!style_s && !p.data_strobe && c.data_strobe) |=> !shared_bus_lines_oe;
  endproperty
  a_rd_end_we: assert property (p_rd_end_we)
    else $error("bus held after rising data strobe");

  property p_pf_block;
    @(posedge sys_clk) disable iff (!rstn) pf_s |=> !req_valid_q;
  endproperty
  a_pf_block: assert property (p_pf_block)
    else $error("access under power fail");

  property p_cs_block;
    @(posedge sys_clk) disable iff (!rstn) c.cs_n |=> !req_valid_q && !shared_bus_lines_oe;
  endproperty
  a_cs_block: assert property (p_cs_block)
    else $error("access without select");

  property p_addr_clear;
    @(posedge sys_clk) disable iff (!rstn) (!p.addr_strobe && c.addr_strobe) |=> !addr_ok_q;
  endproperty
  a_addr_clear: assert property (p_addr_clear)
    else $error("address not dropped");

  property p_addr_latch;
    @(posedge sys_clk) disable iff (!rstn) (p.addr_strobe && !c.addr_strobe) |=> addr_q == $past(bus_s);
  endproperty
  a_addr_latch: assert property (p_addr_latch)
    else $error("address not latched");

  property p_wr_data;
    @(posedge sys_clk) disable iff (!rstn)
      (wr_edge && sel && addr_ok_q) |=> req_valid_q && req_q.data == $past(bus_s);
  endproperty
  a_wr_data: assert property (p_wr_data)
    else $error("write lost");

  property p_wr_once;
    @(posedge sys_clk) disable iff (!rstn) req_valid_q |=> !req_valid_q;
  endproperty
  a_wr_once: assert property (p_wr_once)
    else $error("write repeated");

  property p_osc_float;
    @(posedge sys_clk) disable iff (!rstn) ext_s |=> !osc_output_oe;
  endproperty
  a_osc_float: assert property (p_osc_float)
    else $error("osc output not floated");

  c_write: cover property (@(posedge sys_clk) req_valid_q);
  c_read: cover property (@(posedge sys_clk) rd_strobe_q);
  c_we_read: cover property (@(posedge sys_clk) !style_s && rd_strobe_q);
  c_tick: cover property (@(posedge sys_clk) tick_q);
endmodule // mbb_host_port

// File: design/mbb_pkg.sv
// package for the muxed byte bus host port
package mbb_pkg;
  localparam int DATA_W = 8;
  localparam int OSC_HZ = 32768;
  localparam int SYS_HZ = 20000000;
  // sys_clk cycles per timebase tick, rounded down
  localparam int TICK_CYC = SYS_HZ / OSC_HZ;

  typedef struct packed {
    logic addr_strobe;
    logic data_strobe;
    logic rw;
    logic cs_n;
  } mbb_ctl_s;

  typedef struct packed {
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic wr;
  } mbb_req_s;
endpackage

// File: design/mbb_sync.sv
// two-flop synchroniser, one per bit
`timescale 1ns/1ps
module mbb_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // mbb_sync

// File: testbench/mbb_host_model.sv
// host model driving the muxed byte bus pins
`timescale 1ns/1ps
module mbb_host_model (
  input wire logic sys_clk,
  input wire logic style,
  output mbb_pkg::mbb_ctl_s ctl,
  output logic [7:0] bus
);
  initial bus = 8'h00;
  task automatic go(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic idle(input logic c);
    ctl = {1'b0, ~style, 1'b1, c};
  endtask
  // pins held 2..6 cycles so the sync chain sees every level
  task automatic xfer(input logic c, input logic w, input logic [7:0] a, input logic [7:0] d);
    ctl.cs_n = c;
    bus = a;
    ctl.addr_strobe = 1'b1;
    go(4);
    ctl.addr_strobe = 1'b0;
    go(4);
    bus = w ? d : ~a;
    if (style)
      ctl = {1'b0, 1'b1, ~w, c};
    else if (w)
      ctl.rw = 1'b0;
    else
      ctl.data_strobe = 1'b0;
    go(6);
    if (style)
      ctl.data_strobe = 1'b0; // rw held past the falling strobe
    else
      idle(c);
    go(6);
    idle(1'b1);
    bus = ~bus; // a released bus never keeps its last value
    go(2); // let edges pass before the next access
  endtask
endmodule // mbb_host_model

// File: testbench/tb.sv
// self-checking bench for the muxed byte bus host port
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %0t %0h %0h", $time, g, e); end end
module tb;
  logic sys_clk, rstn, style, pf, ext, osc, oe, ooe, oo, tick, rv, rs;
  logic [7:0] bo, bus, ra, rd, cur_a, a, d;
  mbb_pkg::mbb_ctl_s ctl;
  mbb_pkg::mbb_req_s req;
  int fail_count, tests_run, oe_cnt, rs_cnt, osc_rise, tick_cnt;
  logic [16:0] wq[$];
  logic [16:0] exp_req;
  logic [2:0] kinds [6] = '{3'h1, 3'h0, 3'h5, 3'h3, 3'h4, 3'h2};
  mbb_host_model host (.sys_clk(sys_clk), .style(style), .ctl(ctl), .bus(bus));
  mbb_host_port dut (.sys_clk(sys_clk), .rstn(rstn), .bus_style_select(style), .ctl_pins(ctl),
    .shared_bus_lines_i(oe ? bo : bus), .shared_bus_lines_o(bo), .shared_bus_lines_oe(oe),
    .power_fail(pf), .ext_osc_sel(ext), .osc_input(osc), .osc_output(oo), .osc_output_oe(ooe),
    .tick_q(tick), .req_q(req), .req_valid_q(rv), .rd_strobe_q(rs), .rd_addr_q(ra), .rd_data(rd));
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial
  begin
    osc = 1'b0;
    forever #15259 osc = ~osc;
  end
  always @(posedge osc) osc_rise++;
  always @(posedge sys_clk)
  begin
    if (tick === 1'b1) tick_cnt++;
    if (rs === 1'b1) rs_cnt++;
    if (oe === 1'b1)
    begin
      oe_cnt++;
      `CHK(bo, rd)
      `CHK(ra, cur_a)
    end
    if (rv === 1'b1)
    begin
      `CHK(wq.size() > 0, 1'b1)
      if (wq.size() > 0)
      begin
        exp_req = wq.pop_front();
        `CHK(req, exp_req)
      end
    end
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // watchdog: every access is fixed length, so a hang means a broken bench
  initial
  begin
    #3000000;
    fail_count++;
    complete_run();
  end
  initial
  begin
    rstn = 1'b0;
    style = 1'b1;
    pf = 1'b0;
    ext = 1'b0;
    rd = 8'h00;
    cur_a = 8'h00;
    host.idle(1'b1);
    void'($urandom(32'h97B4));
    repeat (8) @(negedge sys_clk);
    rstn = 1'b1;
    host.go(3);
    for (int s = 1; s >= 0; s--)
    begin
      style = s[0];
      ext = s[0];
      host.idle(1'b1);
      host.go(4);
      `CHK(ooe, ~ext)
      // kinds: {cs_n, power_fail, write}
      repeat (4) foreach (kinds[k])
      begin
        a = 8'($urandom);
        d = 8'($urandom);
        rd = 8'($urandom);
        cur_a = a;
        pf = kinds[k][1];
        oe_cnt = 0;
        if (kinds[k] == 3'h1) wq.push_back({a, d, 1'b1});
        host.xfer(kinds[k][2], kinds[k][0], a, d);
        `CHK(oe_cnt > 0, kinds[k] == 3'h0)
        `CHK(oe, 1'b0)
      end
    end
    host.go(10);
    `CHK(wq.size(), 0)
    `CHK(rs_cnt, 8)
    // a rise only a few cycles old would not yet show as a tick
    for (int i = 0; i < 700 && osc !== 1'b0; i++)
      host.go(1);
    host.go(4);
    `CHK(osc, 1'b0)
    `CHK(tick_cnt, osc_rise)
    `CHK(oo, 1'b1)
    complete_run();
  end
endmodule // tb
